// [hw/core_sfr_bank.sv]
/*
  Special-function register bank of an 8-bit core: generic registers
  with their reset values, result and helper registers, status word
  with bank select and hardware parity, stack pointer, dual data pointer
  and paged external address byte.
  Assumes the core presents one direct or indirect access per cycle and
  drives the flag, result, stack and pointer update strobes itself.
*/
`timescale 1ns/1ps

// Summary of operation
// - Reset loads table values: ports 0xff, stack 0x07, stretch 0x01, serial reload bytes as below, others zero.
// - Serial 0 reload low byte resets to 0xd9.
// - Serial 0 reload high byte resets to 0x03, giving reload 0x3d9.
// - Serial 1 reload high byte resets to 0x03, low byte to zero.
// - Power and baud control at 0x87 holds speed, idle, stop bits; resets zero.
// - Baud rate control at 0xd8 uses only its top bit.
// - Register 0xbf gives upper address byte for paged external moves.
// - Register 0xc8 selects polarity of external interrupts two and three.
// - Result register at 0xe0 is the default operand source and destination.
// - Helper at 0xf0 serves multiply and divide, else free scratch storage.
// - Status bits 4 and 3 select the working register bank base.
// - Status bit 0 is hardware parity making total ones with result even.
// - Status bit 5 is a free software flag.
// - Pointer select at 0x92 resets zero, first data pointer active.
// - Pointer select bit 0 picks active pointer; switching keeps both contents.
// - Stack pointer increments before each push, first byte at 0x08.
// - Unimplemented addresses read zero; writes have no effect.
// - Registers answer direct addressing only; indirect goes to upper RAM.
module core_sfr_bank
  import core_sfr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic result_wr_en,
  input wire logic [7:0] result_wr_data,
  input wire flag_upd_type flag_upd,
  input wire logic helper_wr_en,
  input wire logic [7:0] helper_wr_data,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic pointer_wr_en,
  input wire logic [15:0] pointer_wr_data,
  output logic [7:0] result_register,
  output logic [7:0] mul_div_helper,
  output logic [7:0] program_status,
  output logic [7:0] stack_pointer,
  output logic [15:0] active_data_pointer,
  output logic [4:0] bank_base,
  output logic [7:0] page_address_high,
  output logic [7:0] port0_latch,
  output logic [7:0] port1_latch,
  output logic [7:0] port2_latch,
  output logic [7:0] port3_latch,
  output logic [7:0] ext_irq_polarity,
  output logic [2:0] memory_stretch,
  output logic [7:0] power_and_baud_control,
  output logic baud_select,
  output logic [9:0] serial0_reload,
  output logic [9:0] serial1_reload
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------

  // Generic registers kept in the storage array
  function automatic logic in_file(input logic [7:0] a);
    case (a)
      ADDR_PORT0, ADDR_DP0_LOW, ADDR_DP0_HIGH, ADDR_DP1_LOW, ADDR_DP1_HIGH,
      ADDR_POWER, ADDR_TIMER_CTRL, ADDR_TIMER_MODE, ADDR_TIMER0_LOW,
      ADDR_TIMER1_LOW, ADDR_TIMER0_HIGH, ADDR_TIMER1_HIGH, ADDR_STRETCH,
      ADDR_PORT1, ADDR_PTR_SELECT, ADDR_SER0_CTRL, ADDR_SER0_BUF, ADDR_IRQ_EN2,
      ADDR_SER1_CTRL, ADDR_SER1_BUF, ADDR_SER1_REL_LOW, ADDR_PORT2, ADDR_IRQ_EN0,
      ADDR_IRQ_PRI0, ADDR_SER0_REL_LOW, ADDR_PORT3, ADDR_IRQ_EN1, ADDR_IRQ_PRI1,
      ADDR_SER0_REL_HIGH, ADDR_SER1_REL_HIGH, ADDR_PAGE_HIGH, ADDR_IRQ_REQ,
      ADDR_IRQ_POLARITY, ADDR_BAUD: in_file = 1'b1;
      default: in_file = 1'b0;
    endcase
  endfunction

  // Reset value of each array entry
  function automatic logic [7:0] reset_of(input logic [7:0] a);
    case (a)
      ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3: reset_of = RST_PORT;
      ADDR_STRETCH: reset_of = RST_STRETCH;
      ADDR_SER0_REL_LOW: reset_of = RST_SER0_REL_LOW;
      ADDR_SER0_REL_HIGH: reset_of = RST_SER0_REL_HIGH;
      ADDR_SER1_REL_HIGH: reset_of = RST_SER1_REL_HIGH;
      default: reset_of = RST_ZERO;
    endcase
  endfunction

  // Even parity over a byte
  function automatic logic parity_of(input logic [7:0] d);
    parity_of = ^d;
  endfunction

  // ----------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------
  logic [7:0] sfr_file [0:127];
  logic [7:0] status_q;
  logic [6:0] req_index;
  logic direct_hit;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] next_result;
  logic [7:0] next_read;
  logic pointer_sel;
  logic status_write;
  logic result_write;
  logic helper_write;
  logic stack_write;
  logic dp0_update;
  logic dp1_update;

  // Only direct accesses in the upper half reach the bank
  assign req_index = sfr_req.addr[6:0];
  assign direct_hit = sfr_req.direct & sfr_req.addr[7];
  assign wr_hit = direct_hit & sfr_req.wr;
  assign rd_hit = direct_hit & sfr_req.rd;
  assign pointer_sel = sfr_file[ADDR_PTR_SELECT[6:0]][BIT_PTR_SELECT];

  // Software writes to the registers kept outside the array
  assign status_write = wr_hit && (sfr_req.addr == ADDR_STATUS);
  assign result_write = wr_hit && (sfr_req.addr == ADDR_RESULT);
  assign helper_write = wr_hit && (sfr_req.addr == ADDR_HELPER);
  assign stack_write = wr_hit && (sfr_req.addr == ADDR_STACK);

  // Core pointer loads go to the selected pair only
  assign dp0_update = pointer_wr_en && !pointer_sel;
  assign dp1_update = pointer_wr_en && pointer_sel;

  // ----------------------------------------------------------------
  // Generic register storage
  // ----------------------------------------------------------------

  // Software writes and pointer updates into the array
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 128; i++) begin
        sfr_file[i] <= reset_of(8'(i) | 8'h80);
      end
    end else begin
      if (wr_hit && in_file(sfr_req.addr)) begin
        sfr_file[req_index] <= sfr_req.wdata;
      end
      if (dp0_update) begin
        sfr_file[ADDR_DP0_LOW[6:0]] <= pointer_wr_data[7:0];
        sfr_file[ADDR_DP0_HIGH[6:0]] <= pointer_wr_data[15:8];
      end
      if (dp1_update) begin
        sfr_file[ADDR_DP1_LOW[6:0]] <= pointer_wr_data[7:0];
        sfr_file[ADDR_DP1_HIGH[6:0]] <= pointer_wr_data[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Result register and parity
  // ----------------------------------------------------------------

  // Core result wins over a software write in the same cycle
  always_comb begin
    next_result = result_register;
    if (result_write) begin
      next_result = sfr_req.wdata;
    end
    if (result_wr_en) begin
      next_result = result_wr_data;
    end
  end

  // Result register storage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result_register <= RST_ZERO;
    end else begin
      result_register <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Multiply and divide helper
  // ----------------------------------------------------------------

  // Scratch storage, overwritten by multiply and divide
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mul_div_helper <= RST_ZERO;
    end else if (helper_wr_en) begin
      mul_div_helper <= helper_wr_data;
    end else if (helper_write) begin
      mul_div_helper <= sfr_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------

  // Software bits, then arithmetic flags which win over software
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= RST_ZERO;
    end else begin
      if (status_write) begin
        status_q[7:1] <= sfr_req.wdata[7:1];
      end
      if (flag_upd.carry_we) begin
        status_q[BIT_CARRY] <= flag_upd.carry;
      end
      if (flag_upd.half_we) begin
        status_q[BIT_HALF_CARRY] <= flag_upd.half;
      end
      if (flag_upd.range_we) begin
        status_q[BIT_SIGNED_RANGE] <= flag_upd.range;
      end
      status_q[BIT_PARITY] <= parity_of(next_result);
    end
  end

  assign program_status = status_q;

  // Bank base follows the select bits of the stored word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bank_base <= 5'h00;
    end else if (status_write) begin
      bank_base <= {sfr_req.wdata[BIT_BANK_HIGH], sfr_req.wdata[BIT_BANK_LOW], BANK_OFFSET_ZERO};
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------

  // Pre-increment on push, post-decrement on pop; software write first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stack_pointer <= RST_STACK;
    end else if (stack_write) begin
      stack_pointer <= sfr_req.wdata;
    end else if (stack_push && !stack_pop) begin
      stack_pointer <= stack_pointer + 8'h01;
    end else if (stack_pop && !stack_push) begin
      stack_pointer <= stack_pointer - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Source selection; unmapped addresses read zero
  always_comb begin
    next_read = RST_ZERO;
    if (in_file(sfr_req.addr)) begin
      next_read = sfr_file[req_index];
    end else begin
      case (sfr_req.addr)
        ADDR_STACK: next_read = stack_pointer;
        ADDR_STATUS: next_read = status_q;
        ADDR_RESULT: next_read = result_register;
        ADDR_HELPER: next_read = mul_div_helper;
        default: next_read = RST_ZERO;
      endcase
    end
  end

  // Read strobe, one cycle after the request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= rd_hit;
    end
  end

  // Read data, held until the next accepted read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= RST_ZERO;
    end else if (rd_hit) begin
      sfr_rdata <= next_read;
    end
  end

  // ----------------------------------------------------------------
  // Derived outputs
  // ----------------------------------------------------------------

  // Copy of the selected data pointer, one cycle behind storage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      active_data_pointer <= 16'h0000;
    end else if (pointer_sel) begin
      active_data_pointer <= {sfr_file[ADDR_DP1_HIGH[6:0]], sfr_file[ADDR_DP1_LOW[6:0]]};
    end else begin
      active_data_pointer <= {sfr_file[ADDR_DP0_HIGH[6:0]], sfr_file[ADDR_DP0_LOW[6:0]]};
    end
  end

  // Stretch field for external memory timing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memory_stretch <= RST_STRETCH[STRETCH_MSB:0];
    end else begin
      memory_stretch <= sfr_file[ADDR_STRETCH[6:0]][STRETCH_MSB:0];
    end
  end

  // Only the top bit of the baud byte has a function
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      baud_select <= 1'b0;
    end else begin
      baud_select <= sfr_file[ADDR_BAUD[6:0]][BIT_BAUD_SELECT];
    end
  end

  // Ten-bit reload values; the high byte gives two bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial0_reload <= {RST_SER0_REL_HIGH[RELOAD_HIGH_MSB:0], RST_SER0_REL_LOW};
      serial1_reload <= {RST_SER1_REL_HIGH[RELOAD_HIGH_MSB:0], RST_ZERO};
    end else begin
      serial0_reload <= {sfr_file[ADDR_SER0_REL_HIGH[6:0]][RELOAD_HIGH_MSB:0],
                         sfr_file[ADDR_SER0_REL_LOW[6:0]]};
      serial1_reload <= {sfr_file[ADDR_SER1_REL_HIGH[6:0]][RELOAD_HIGH_MSB:0],
                         sfr_file[ADDR_SER1_REL_LOW[6:0]]};
    end
  end

  // Plain register outputs straight from the storage array
  assign port0_latch = sfr_file[ADDR_PORT0[6:0]];
  assign port1_latch = sfr_file[ADDR_PORT1[6:0]];
  assign port2_latch = sfr_file[ADDR_PORT2[6:0]];
  assign port3_latch = sfr_file[ADDR_PORT3[6:0]];
  assign page_address_high = sfr_file[ADDR_PAGE_HIGH[6:0]];
  assign ext_irq_polarity = sfr_file[ADDR_IRQ_POLARITY[6:0]];
  assign power_and_baud_control = sfr_file[ADDR_POWER[6:0]];

endmodule

// [hw/core_sfr_pkg.sv]
/*
  Shared definitions for the core special-function register bank:
  register addresses, reset values, status-word bit positions and the
  packed carriers for register access and flag updates.
  Assumes an 8-bit core that reaches its registers by direct address.
*/
package core_sfr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_STACK = 8'h81;
  localparam logic [7:0] ADDR_DP0_LOW = 8'h82;
  localparam logic [7:0] ADDR_DP0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_DP1_LOW = 8'h84;
  localparam logic [7:0] ADDR_DP1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POWER = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_STRETCH = 8'h8e;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PTR_SELECT = 8'h92;
  localparam logic [7:0] ADDR_SER0_CTRL = 8'h98;
  localparam logic [7:0] ADDR_SER0_BUF = 8'h99;
  localparam logic [7:0] ADDR_IRQ_EN2 = 8'h9a;
  localparam logic [7:0] ADDR_SER1_CTRL = 8'h9b;
  localparam logic [7:0] ADDR_SER1_BUF = 8'h9c;
  localparam logic [7:0] ADDR_SER1_REL_LOW = 8'h9d;
  localparam logic [7:0] ADDR_PORT2 = 8'ha0;
  localparam logic [7:0] ADDR_IRQ_EN0 = 8'ha8;
  localparam logic [7:0] ADDR_IRQ_PRI0 = 8'ha9;
  localparam logic [7:0] ADDR_SER0_REL_LOW = 8'haa;
  localparam logic [7:0] ADDR_PORT3 = 8'hb0;
  localparam logic [7:0] ADDR_IRQ_EN1 = 8'hb8;
  localparam logic [7:0] ADDR_IRQ_PRI1 = 8'hb9;
  localparam logic [7:0] ADDR_SER0_REL_HIGH = 8'hba;
  localparam logic [7:0] ADDR_SER1_REL_HIGH = 8'hbb;
  localparam logic [7:0] ADDR_PAGE_HIGH = 8'hbf;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_POLARITY = 8'hc8;
  localparam logic [7:0] ADDR_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_BAUD = 8'hd8;
  localparam logic [7:0] ADDR_RESULT = 8'he0;
  localparam logic [7:0] ADDR_HELPER = 8'hf0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_STACK = 8'h07;
  localparam logic [7:0] RST_STRETCH = 8'h01;
  localparam logic [7:0] RST_SER0_REL_LOW = 8'hd9;
  localparam logic [7:0] RST_SER0_REL_HIGH = 8'h03;
  localparam logic [7:0] RST_SER1_REL_HIGH = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CARRY = 7;
  localparam int BIT_HALF_CARRY = 6;
  localparam int BIT_USER_FLAG_ZERO = 5;
  localparam int BIT_BANK_HIGH = 4;
  localparam int BIT_BANK_LOW = 3;
  localparam int BIT_SIGNED_RANGE = 2;
  localparam int BIT_USER_FLAG_ONE = 1;
  localparam int BIT_PARITY = 0;
  localparam int BIT_PTR_SELECT = 0;
  localparam int BIT_BAUD_SELECT = 7;
  localparam int STRETCH_MSB = 2;
  localparam int RELOAD_HIGH_MSB = 1;
  localparam logic [2:0] BANK_OFFSET_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic direct;
  } sfr_req_type;

  typedef struct packed {
    logic carry_we;
    logic carry;
    logic half_we;
    logic half;
    logic range_we;
    logic range;
  } flag_upd_type;

endpackage

// [sim/core_sfr_checker.sv]
/*
  Port-level checks for the register bank.
  Assumes one clock mclk and the active-low asynchronous reset rst_b.
*/
`timescale 1ns/1ps

module core_sfr_checker
  import core_sfr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire sfr_req_type sfr_req,
  input wire logic sfr_rvalid,
  input wire logic result_wr_en,
  input wire logic [7:0] result_wr_data,
  input wire flag_upd_type flag_upd,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [7:0] result_register,
  input wire logic [7:0] program_status,
  input wire logic [7:0] stack_pointer,
  input wire logic [4:0] bank_base,
  input wire logic [7:0] page_address_high
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ----
  // Access decode
  // ----
  logic rd_ok;
  assign rd_ok = sfr_req.rd && sfr_req.direct && sfr_req.addr[7];
  function automatic logic sw(input logic [7:0] a);
    return sfr_req.wr && sfr_req.direct && (sfr_req.addr == a);
  endfunction

  // ----
  // Properties
  // ----
  property p_read; rd_ok |=> sfr_rvalid; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_pulse; !rd_ok |=> !sfr_rvalid; endproperty
  a_pulse: assert property (p_pulse) else $error("read valid without direct read");
  property p_parity; program_status[BIT_PARITY] == ^result_register; endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  property p_bank; bank_base == {program_status[4:3], 3'h0}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_push;
    stack_push && !stack_pop && !sw(ADDR_STACK) |=> stack_pointer == $past(stack_pointer) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not increment");
  property p_result; result_wr_en |=> result_register == $past(result_wr_data); endproperty
  a_result: assert property (p_result) else $error("result write lost");
  property p_carry; flag_upd.carry_we |=> program_status[BIT_CARRY] == $past(flag_upd.carry); endproperty
  a_carry: assert property (p_carry) else $error("carry update lost");
  property p_page; sw(ADDR_PAGE_HIGH) |=> page_address_high == $past(sfr_req.wdata); endproperty
  a_page: assert property (p_page) else $error("page byte write lost");

  c_read: cover property (rd_ok);
  c_push_pop: cover property (stack_push ##1 stack_pop);
  c_bank3: cover property (bank_base == 5'h18);
endmodule

bind core_sfr_bank core_sfr_checker u_checker (.mclk(mclk), .rst_b(rst_b), .sfr_req(sfr_req),
  .sfr_rvalid(sfr_rvalid), .result_wr_en(result_wr_en), .result_wr_data(result_wr_data),
  .flag_upd(flag_upd), .stack_push(stack_push), .stack_pop(stack_pop), .result_register(result_register),
  .program_status(program_status), .stack_pointer(stack_pointer), .bank_base(bank_base),
  .page_address_high(page_address_high));

// [sim/tb_top.sv]
/*
  Self-checking bench for the register bank: reset values, readback,
  refused accesses, core strobes and derived outputs.
  Assumes the bank and its bound checker.
*/
`timescale 1ns/1ps

module tb_top;
  import core_sfr_pkg::*;
  // ----
  // Signals
  // ----
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  sfr_req_type sfr_req = '0;
  flag_upd_type flag_upd = '0;
  logic result_wr_en = 1'b0, helper_wr_en = 1'b0, stack_push = 1'b0, stack_pop = 1'b0, pointer_wr_en = 1'b0;
  logic [7:0] result_wr_data = 8'h00, helper_wr_data = 8'h00;
  logic [15:0] pointer_wr_data = 16'h0000, active_data_pointer;
  logic [7:0] sfr_rdata, result_register, mul_div_helper, program_status, stack_pointer, page_address_high, q;
  logic [7:0] port0_latch, port1_latch, port2_latch, port3_latch, ext_irq_polarity, power_and_baud_control;
  logic [4:0] bank_base;
  logic [2:0] memory_stretch;
  logic [9:0] serial0_reload, serial1_reload;
  logic sfr_rvalid, baud_select;
  int n_mismatch = 0, n_checks = 0, cycles = 0;
  logic [7:0] regs [38] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
    8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h92, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'ha0, 8'ha8, 8'ha9,
    8'haa, 8'hb0, 8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbf, 8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0, 8'hf0};
  logic [7:0] vals [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'h03};

  core_sfr_bank u_dut (.mclk(mclk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .result_wr_en(result_wr_en), .result_wr_data(result_wr_data),
    .flag_upd(flag_upd), .helper_wr_en(helper_wr_en), .helper_wr_data(helper_wr_data),
    .stack_push(stack_push), .stack_pop(stack_pop), .pointer_wr_en(pointer_wr_en),
    .pointer_wr_data(pointer_wr_data), .result_register(result_register), .mul_div_helper(mul_div_helper),
    .program_status(program_status), .stack_pointer(stack_pointer), .active_data_pointer(active_data_pointer),
    .bank_base(bank_base), .page_address_high(page_address_high), .port0_latch(port0_latch),
    .port1_latch(port1_latch), .port2_latch(port2_latch), .port3_latch(port3_latch),
    .ext_irq_polarity(ext_irq_polarity), .memory_stretch(memory_stretch),
    .power_and_baud_control(power_and_baud_control), .baud_select(baud_select),
    .serial0_reload(serial0_reload), .serial1_reload(serial1_reload));

  // Clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One register access; answer looked at half a cycle after it is taken
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic dir);
    @(negedge mclk);
    sfr_req = '{addr: a, wdata: d, wr: w, rd: !w, direct: dir};
    @(negedge mclk);
    sfr_req = '0;
    chk("sfr_rvalid", !w && dir && a[7], sfr_rvalid);
    q = sfr_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0, 1'b1);
    chk($sformatf("sfr %h", a), e, q);
  endtask

  task automatic stk(input logic pu, input logic po, input logic [7:0] e);
    @(negedge mclk);
    stack_push = pu;
    stack_pop = po;
    @(negedge mclk);
    stack_push = 1'b0;
    stack_pop = 1'b0;
    chk("stack_pointer", e, stack_pointer);
  endtask

  function automatic logic [7:0] rstv(input logic [7:0] a);
    case (a)
      8'h80, 8'h90, 8'ha0, 8'hb0: return 8'hff;
      8'h81: return 8'h07;
      8'h8e: return 8'h01;
      8'haa: return 8'hd9;
      8'hba, 8'hbb: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

  // ----
  // Tests
  // ----
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    foreach (regs[i]) rd(regs[i], rstv(regs[i]));
    chk("serial0_reload", 10'h3d9, serial0_reload);
    chk("serial1_reload", 10'h300, serial1_reload);
    chk("memory_stretch", 3'h1, memory_stretch);
    $display("test reset_values done");
    foreach (regs[i]) begin
      wr(regs[i], ~regs[i]);
      if (!(regs[i] inside {8'h8e, 8'hba, 8'hbb, 8'hd0})) rd(regs[i], ~regs[i]);
    end
    step(1);
    chk("port0_latch", 8'h7f, port0_latch);
    chk("port1_latch", 8'h6f, port1_latch);
    chk("port2_latch", 8'h5f, port2_latch);
    chk("port3_latch", 8'h4f, port3_latch);
    chk("page_address_high", 8'h40, page_address_high);
    chk("ext_irq_polarity", 8'h37, ext_irq_polarity);
    chk("power_and_baud_control", 8'h78, power_and_baud_control);
    chk("serial0_reload", 10'h155, serial0_reload);
    chk("serial1_reload", 10'h062, serial1_reload);
    wr(ADDR_BAUD, 8'h80);
    wr(ADDR_STRETCH, 8'h06);
    step(1);
    chk("baud_select", 1'b1, baud_select);
    chk("memory_stretch", 3'h6, memory_stretch);
    $display("test readback done");
    rd(8'h86, 8'h00);
    wr(8'h86, 8'h55);
    rd(ADDR_POWER, 8'h78);
    acc(ADDR_PAGE_HIGH, 8'h99, 1'b1, 1'b0);
    acc(ADDR_STACK, 8'h00, 1'b0, 1'b0);
    acc(8'h30, 8'h00, 1'b0, 1'b1);
    chk("page_address_high", 8'h40, page_address_high);
    $display("test refused done");
    foreach (vals[i]) begin
      @(negedge mclk);
      result_wr_en = 1'b1;
      result_wr_data = vals[i];
      @(negedge mclk);
      result_wr_en = 1'b0;
      chk("result_register", vals[i], result_register);
      chk("parity", ^vals[i], program_status[0]);
    end
    rd(ADDR_RESULT, 8'h03);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_STATUS, {3'b001, b[1:0], 3'b011});
      chk("bank_base", {b[1:0], 3'h0}, bank_base);
      rd(ADDR_STATUS, {3'b001, b[1:0], 3'b010});
    end
    @(negedge mclk);
    flag_upd = '1;
    helper_wr_en = 1'b1;
    helper_wr_data = 8'hc3;
    sfr_req = '{addr: ADDR_STATUS, wdata: 8'h00, wr: 1'b1, rd: 1'b0, direct: 1'b1};
    @(negedge mclk);
    flag_upd = '0;
    helper_wr_en = 1'b0;
    sfr_req = '0;
    chk("program_status", 8'hc4, program_status);
    chk("mul_div_helper", 8'hc3, mul_div_helper);
    $display("test status done");
    wr(ADDR_STACK, 8'h07);
    stk(1'b1, 1'b0, 8'h08);
    stk(1'b1, 1'b1, 8'h08);
    stk(1'b0, 1'b1, 8'h07);
    wr(ADDR_PTR_SELECT, 8'h00);
    wr(ADDR_DP0_LOW, 8'h11);
    wr(ADDR_DP0_HIGH, 8'h22);
    wr(ADDR_DP1_LOW, 8'h33);
    wr(ADDR_DP1_HIGH, 8'h44);
    step(1);
    chk("active_data_pointer", 16'h2211, active_data_pointer);
    wr(ADDR_PTR_SELECT, 8'h01);
    step(1);
    chk("active_data_pointer", 16'h4433, active_data_pointer);
    @(negedge mclk);
    pointer_wr_en = 1'b1;
    pointer_wr_data = 16'hbeef;
    @(negedge mclk);
    pointer_wr_en = 1'b0;
    rd(ADDR_DP1_HIGH, 8'hbe);
    rd(ADDR_DP0_LOW, 8'h11);
    wr(ADDR_PTR_SELECT, 8'h00);
    step(1);
    chk("active_data_pointer", 16'h2211, active_data_pointer);
    $display("test stack_pointer done");
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    rd(ADDR_STACK, 8'h07);
    rd(ADDR_PTR_SELECT, 8'h00);
    stk(1'b1, 1'b0, 8'h08);
    $display("test second_reset done");
    complete_run();
  end
endmodule
